// ### hdl/lts_ctrl_filter.sv
// Control input conditioning: three-stage synchroniser and 250 ms filter.
// Assumes the raw control may change at any time relative to the clock.
`timescale 1ns/1ns
`default_nettype none
module lts_ctrl_filter
(
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_clk_en,
	input  wire logic i_tick,
	input  wire logic i_raw,
	output var  logic o_level,
	output var  logic o_rise
);
	logic                     sync1;
	logic                     sync2;
	logic                     sync3;
	logic [lts_pkg::CNT_W-1:0] hold;

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			sync1 <= 1'h0;
			sync2 <= 1'h0;
			sync3 <= 1'h0;
		end
		else if (i_clk_en)
		begin
			sync1 <= i_raw;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Any disagreement restarts the hold time, so short pulses vanish
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			hold    <= '0;
			o_level <= 1'h0;
			o_rise  <= 1'h0;
		end
		else if (i_clk_en)
		begin
			o_rise <= 1'h0;
			if ((sync2 != sync3) || (sync3 == o_level))
				hold <= '0;
			else if (i_tick)
			begin
				if (hold == lts_pkg::FILTER_LAST)
				begin
					hold    <= '0;
					o_level <= sync3;
					o_rise  <= sync3;
				end
				else
					hold <= hold + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ### hdl/lts_ms_tick.sv
// Millisecond time base: one-cycle tick every CYCLES clocks.
// Assumes CYCLES is at least 2.
`timescale 1ns/1ns
`default_nettype none
module lts_ms_tick
#(
	parameter int CYCLES = lts_pkg::TICK_CYCLES
)
(
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_clk_en,
	output var  logic o_tick
);
	localparam int          W    = $clog2(CYCLES);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] count;

	// Shared by filter, step and stage one limit
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			count  <= '0;
			o_tick <= 1'h0;
		end
		else if (i_clk_en)
		begin
			count  <= (count == LAST) ? '0 : count + 1'h1;
			o_tick <= (count == LAST);
		end
	end
endmodule
`default_nettype wire

// ### hdl/lts_sequencer.sv
// Lamp test sequencer with APB register slave.
// Assumes lamp requests come from logic on i_clk; operands may be async pins.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module lts_sequencer
#(
	parameter int TICK_CYCLES = lts_pkg::TICK_CYCLES,
	parameter int NUM_SOURCES = lts_pkg::NUM_SOURCES
)
(
	input  wire logic                           i_clk,
	input  wire logic                           i_sys_rst,
	input  wire logic                           i_clk_en,
	input  wire logic                           i_psel,
	input  wire logic                           i_penable,
	input  wire logic                           i_pwrite,
	input  wire logic [lts_pkg::ADDR_W-1:0]     i_paddr,
	input  wire logic [lts_pkg::DATA_W-1:0]     i_pwdata,
	output var  logic [lts_pkg::DATA_W-1:0]     o_prdata,
	output var  logic                           o_pready,
	output var  logic                           o_pslverr,
	input  wire logic [NUM_SOURCES-1:0]         i_operand,
	input  wire logic [lts_pkg::NUM_LAMPS-1:0]  i_lamp_req,
	input  wire logic                           i_reset_button,
	output var  logic [lts_pkg::NUM_LAMPS-1:0]  o_lamp,
	output var  logic                           o_target_clear,
	output var  logic                           o_active,
	output var  logic                           o_start_event
);
	// -------------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------------
	localparam logic [lts_pkg::NUM_LAMPS-1:0] ALL_ON  = {lts_pkg::NUM_LAMPS{1'b1}};
	localparam logic [lts_pkg::NUM_LAMPS-1:0] ALL_OFF = {lts_pkg::NUM_LAMPS{1'b0}};

	lts_pkg::lts_state_type              state;
	logic                                func_enable;
	logic [lts_pkg::SELECT_W-1:0]        source_sel;
	logic                                tick;
	logic                                ctrl_raw;
	logic                                ctrl_level;
	logic                                ctrl_rise;
	logic [lts_pkg::CNT_W-1:0]           ms_cnt;
	logic [lts_pkg::IDX_W-1:0]           idx;
	logic                                lead;
	logic [lts_pkg::NUM_LAMPS-1:0]       shadow;
	lts_pkg::lts_status_type             status;
	logic                                step_done;
	logic                                setup;
	logic                                access;
	logic                                next_err;
	logic [lts_pkg::DATA_W-1:0]          next_rdata;

	// Lamp index order is column major from the top-left panel
	function automatic logic [lts_pkg::NUM_LAMPS-1:0] lamp_bit
	(
		input logic [lts_pkg::IDX_W-1:0] index
	);
		lamp_bit        = ALL_OFF;
		lamp_bit[index] = 1'b1;
	endfunction

	function automatic logic addr_known
	(
		input logic [lts_pkg::ADDR_W-1:0] addr
	);
		addr_known = (addr == lts_pkg::ADDR_CTRL) || (addr == lts_pkg::ADDR_SELECT) ||
			(addr == lts_pkg::ADDR_STATUS) || (addr == lts_pkg::ADDR_SHADOW_LO) ||
			(addr == lts_pkg::ADDR_SHADOW_HI);
	endfunction

	// -------------------------------------------------------------------
	// Time base and control input
	// -------------------------------------------------------------------
	lts_ms_tick
	#(
		.CYCLES (TICK_CYCLES)
	)
	u_tick
	(
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.o_tick    (tick)
	);

	// Out-of-range selection reads as a released control
	assign ctrl_raw = (int'(source_sel) < NUM_SOURCES) ? i_operand[source_sel] : 1'b0;

	lts_ctrl_filter u_filter
	(
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.i_tick    (tick),
		.i_raw     (ctrl_raw),
		.o_level   (ctrl_level),
		.o_rise    (ctrl_rise)
	);

	// -------------------------------------------------------------------
	// Sequencer
	// -------------------------------------------------------------------
	assign step_done = tick && (ms_cnt == lts_pkg::STEP_LAST);

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			state         <= lts_pkg::ST_IDLE;
			ms_cnt        <= '0;
			idx           <= '0;
			lead          <= 1'b0;
			o_active      <= 1'b0;
			o_start_event <= 1'b0;
		end
		else if (i_clk_en)
		begin
			o_start_event <= 1'b0;
			case (state)
				lts_pkg::ST_IDLE:
				begin
					if (func_enable && ctrl_rise)
					begin
						state         <= lts_pkg::ST_ALL_ON;
						ms_cnt        <= '0;
						o_active      <= 1'b1;
						o_start_event <= 1'b1;
					end
				end
				lts_pkg::ST_ALL_ON:
				begin
					if (!func_enable)
					begin
						state    <= lts_pkg::ST_IDLE;
						o_active <= 1'b0;
					end
					else if (!ctrl_level)
					begin
						state  <= lts_pkg::ST_WALK_ON;
						ms_cnt <= '0;
						idx    <= '0;
						lead   <= 1'b1;
					end
					else if (tick)
					begin
						if (ms_cnt == lts_pkg::STAGE1_LAST)
						begin
							state    <= lts_pkg::ST_IDLE;
							o_active <= 1'b0;
						end
						else
							ms_cnt <= ms_cnt + 16'h0001;
					end
				end
				lts_pkg::ST_WALK_ON, lts_pkg::ST_WALK_OFF:
				begin
					if (!func_enable || ctrl_rise)
					begin
						state    <= lts_pkg::ST_IDLE;
						o_active <= 1'b0;
					end
					else if (step_done)
					begin
						ms_cnt <= '0;
						if (lead)
							lead <= 1'b0;
						else if (idx != lts_pkg::LAST_IDX)
							idx <= idx + 6'h01;
						else if (state == lts_pkg::ST_WALK_ON)
						begin
							state <= lts_pkg::ST_WALK_OFF;
							idx   <= '0;
							lead  <= 1'b1;
						end
						else
						begin
							state    <= lts_pkg::ST_IDLE;
							o_active <= 1'b0;
						end
					end
					else if (tick)
						ms_cnt <= ms_cnt + 16'h0001;
				end
				default:
				begin
					state    <= lts_pkg::ST_IDLE;
					o_active <= 1'b0;
				end
			endcase
		end
	end

	// -------------------------------------------------------------------
	// Lamp drive
	// -------------------------------------------------------------------
	// Relay requests keep landing in the shadow even mid-test
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			shadow <= ALL_OFF;
		else if (i_clk_en)
			shadow <= i_lamp_req;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			o_lamp <= ALL_OFF;
		else if (i_clk_en)
		begin
			case (state)
				lts_pkg::ST_ALL_ON:   o_lamp <= ALL_ON;
				lts_pkg::ST_WALK_ON:  o_lamp <= lead ? ALL_OFF : lamp_bit(idx);
				lts_pkg::ST_WALK_OFF: o_lamp <= lead ? ALL_ON : ~lamp_bit(idx);
				default:              o_lamp <= shadow;
			endcase
		end
	end

	// Faceplate reset pulse passes through only outside a test
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			o_target_clear <= 1'b0;
		else if (i_clk_en)
			o_target_clear <= i_reset_button && (state == lts_pkg::ST_IDLE) &&
				!(func_enable && ctrl_rise);
	end

	// -------------------------------------------------------------------
	// APB slave
	// -------------------------------------------------------------------
	assign setup    = i_psel && !i_penable;
	assign access   = i_psel && i_penable;
	assign o_pready = 1'b1;

	assign status = '{index: idx, lead: lead, state: state, active: o_active};

	always_comb
	begin
		next_rdata = '0;
		next_err   = !addr_known(i_paddr);
		if (i_paddr == lts_pkg::ADDR_CTRL)
			next_rdata[lts_pkg::CTRL_ENABLE_BIT] = func_enable;
		else if (i_paddr == lts_pkg::ADDR_SELECT)
			next_rdata[lts_pkg::SELECT_W-1:0] = source_sel;
		else if (i_paddr == lts_pkg::ADDR_STATUS)
			next_rdata[$bits(lts_pkg::lts_status_type)-1:0] = status;
		else if (i_paddr == lts_pkg::ADDR_SHADOW_LO)
			next_rdata = shadow[lts_pkg::DATA_W-1:0];
		else if (i_paddr == lts_pkg::ADDR_SHADOW_HI)
			next_rdata[lts_pkg::NUM_LAMPS-lts_pkg::DATA_W-1:0] =
				shadow[lts_pkg::NUM_LAMPS-1:lts_pkg::DATA_W];
		if (i_pwrite && (i_paddr != lts_pkg::ADDR_CTRL) && (i_paddr != lts_pkg::ADDR_SELECT))
			next_err = 1'b1;
	end

	// Answer is prepared in setup so pready can stay high
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_prdata  <= '0;
			o_pslverr <= 1'b0;
		end
		else if (i_clk_en && setup)
		begin
			o_prdata  <= i_pwrite ? '0 : next_rdata;
			o_pslverr <= next_err;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			func_enable <= lts_pkg::ENABLE_RESET;
			source_sel  <= lts_pkg::SELECT_RESET;
		end
		else if (i_clk_en && access && i_pwrite)
		begin
			if (i_paddr == lts_pkg::ADDR_CTRL)
				func_enable <= i_pwdata[lts_pkg::CTRL_ENABLE_BIT];
			else if (i_paddr == lts_pkg::ADDR_SELECT)
				source_sel <= i_pwdata[lts_pkg::SELECT_W-1:0];
		end
	end

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	AST_START_NEEDS_ENABLE: assert property (
		o_start_event && $past(i_clk_en) |-> $past(func_enable) && $past(ctrl_rise))
		else $error("test started while disabled or without a rising control");

	AST_STAGE1_ALL_ON: assert property (
		$past(state == lts_pkg::ST_ALL_ON) && $past(i_clk_en) |-> o_lamp == ALL_ON)
		else $error("stage one not lighting every lamp");

	AST_STAGE1_LIMIT: assert property (
		state == lts_pkg::ST_ALL_ON |-> ms_cnt <= lts_pkg::STAGE1_LAST)
		else $error("stage one ran past its time limit");

	AST_RELEASE_ADVANCES: assert property (
		state == lts_pkg::ST_ALL_ON && func_enable && !ctrl_level && i_clk_en
		|=> state == lts_pkg::ST_WALK_ON && lead && idx == '0)
		else $error("release in stage one did not start stage two");

	AST_WALK_SINGLE_ON: assert property (
		$past(state == lts_pkg::ST_WALK_ON && !lead) && $past(i_clk_en) |-> $onehot(o_lamp))
		else $error("stage two lit other than one lamp");

	AST_WALK_SINGLE_OFF: assert property (
		$past(state == lts_pkg::ST_WALK_OFF && !lead) && $past(i_clk_en) |-> $onehot(~o_lamp))
		else $error("stage three darkened other than one lamp");

	AST_STAGE_CHAIN: assert property (
		state == lts_pkg::ST_WALK_ON && !lead && idx == lts_pkg::LAST_IDX && step_done &&
		func_enable && !ctrl_rise && i_clk_en |=> state == lts_pkg::ST_WALK_OFF && lead)
		else $error("stage three did not follow stage two");

	AST_ABORT: assert property (
		(state == lts_pkg::ST_WALK_ON || state == lts_pkg::ST_WALK_OFF) && ctrl_rise && i_clk_en
		|=> state == lts_pkg::ST_IDLE ##1 o_lamp == $past(shadow))
		else $error("press during walk did not abort and restore lamps");

	AST_TARGET_BLOCK: assert property (
		o_active |=> !o_target_clear)
		else $error("target clear passed during a test");

	AST_ACTIVE_TRACKS: assert property (
		o_active == (state != lts_pkg::ST_IDLE))
		else $error("active flag disagrees with sequencer");

	COV_STAGE3: cover property (state == lts_pkg::ST_WALK_OFF && !lead);
	COV_TIMEOUT: cover property (
		state == lts_pkg::ST_ALL_ON ##1 state == lts_pkg::ST_IDLE && ctrl_level);
	COV_ABORT: cover property (
		state == lts_pkg::ST_WALK_ON && ctrl_rise ##1 state == lts_pkg::ST_IDLE);
	COV_FULL_RUN: cover property (
		state == lts_pkg::ST_WALK_OFF && !ctrl_rise ##1 state == lts_pkg::ST_IDLE);
endmodule
`default_nettype wire

// ### inc/lts_pkg.sv
// Constants, types and register map of the lamp test sequencer.
// Assumes a 10 MHz system clock and a millisecond tick derived from it.
package lts_pkg;

	// -------------------------------------------------------------------
	// Sizes
	// -------------------------------------------------------------------
	localparam int NUM_LAMPS   = 62;
	localparam int NUM_SOURCES = 16;
	localparam int SELECT_W    = 4;
	localparam int IDX_W       = 6;
	localparam int CNT_W       = 16;
	localparam int DATA_W      = 32;
	localparam int ADDR_W      = 12;

	// -------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 100;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_MS        = 1;
	localparam int FILTER_MS      = 250;
	localparam int STEP_S         = 1;
	localparam int STAGE1_MAX_MIN = 1;
	localparam logic [CNT_W-1:0] FILTER_TICKS = CNT_W'(FILTER_MS / TICK_MS);
	localparam logic [CNT_W-1:0] STEP_TICKS   = CNT_W'(STEP_S * 1000 / TICK_MS);
	localparam logic [CNT_W-1:0] STAGE1_TICKS = CNT_W'(STAGE1_MAX_MIN * 60000 / TICK_MS);
	localparam logic [CNT_W-1:0] FILTER_LAST  = FILTER_TICKS - 16'h0001;
	localparam logic [CNT_W-1:0] STEP_LAST    = STEP_TICKS - 16'h0001;
	localparam logic [CNT_W-1:0] STAGE1_LAST  = STAGE1_TICKS - 16'h0001;
	localparam logic [IDX_W-1:0] LAST_IDX     = IDX_W'(NUM_LAMPS - 1);

	// -------------------------------------------------------------------
	// Register map
	// -------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_CTRL      = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_SELECT    = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_STATUS    = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_SHADOW_LO = 12'h00C;
	localparam logic [ADDR_W-1:0] ADDR_SHADOW_HI = 12'h010;
	localparam int                CTRL_ENABLE_BIT = 0;
	localparam logic              ENABLE_RESET    = 1'h0;
	localparam logic [SELECT_W-1:0] SELECT_RESET  = 4'h0;

	// -------------------------------------------------------------------
	// Types
	// -------------------------------------------------------------------
	typedef enum logic [3:0]
	{
		ST_IDLE     = 4'h1,
		ST_ALL_ON   = 4'h2,
		ST_WALK_ON  = 4'h4,
		ST_WALK_OFF = 4'h8
	} lts_state_type;

	typedef struct packed
	{
		logic [IDX_W-1:0] index;
		logic             lead;
		lts_state_type    state;
		logic             active;
	} lts_status_type;

endpackage

// ### test/lts_partner.sv
// Far-side model: control operand pins and relay lamp requests.
// Assumes the bench calls each task from one process at a time.
`timescale 1ns/1ns
`default_nettype none
module lts_partner
#(
	parameter int TICK = 2
)
(
	input  wire logic                              i_clk,
	output var  logic [lts_pkg::NUM_SOURCES-1:0]   o_operand,
	output var  logic [lts_pkg::NUM_LAMPS-1:0]     o_lamp_req
);
	initial
	begin
		o_operand  = '0;
		o_lamp_req = '0;
	end

	// Pulses under 250 ms only when a scenario wants one ignored
	task automatic press(input int idx, input int ms);
		@(posedge i_clk);
		o_operand[idx] <= 1'b1;
		repeat (ms * TICK) @(posedge i_clk);
		o_operand[idx] <= 1'b0;
	endtask

	task automatic set_lamps(input logic [lts_pkg::NUM_LAMPS-1:0] v);
		@(posedge i_clk);
		o_lamp_req <= v;
	endtask
endmodule
`default_nettype wire

// ### test/lts_sequencer_tb_top.sv
// Self-checking bench of the lamp test sequencer.
// Assumes lts_partner drives operands and lamp requests; tick cut to 2 clocks.
`timescale 1ns/1ns
`default_nettype none
module lts_sequencer_tb_top;
	localparam int MS   = 2;
	localparam int STEP = 1000 * MS;
	localparam logic [lts_pkg::NUM_LAMPS-1:0] ALL = '1;
	localparam logic [lts_pkg::NUM_LAMPS-1:0] PAT = 62'h2AAA00005555F00F;

	logic                              i_clk;
	logic                              i_sys_rst;
	logic                              i_clk_en;
	logic                              i_psel;
	logic                              i_penable;
	logic                              i_pwrite;
	logic [lts_pkg::ADDR_W-1:0]        i_paddr;
	logic [lts_pkg::DATA_W-1:0]        i_pwdata;
	logic [lts_pkg::DATA_W-1:0]        o_prdata;
	logic                              o_pready;
	logic                              o_pslverr;
	logic [lts_pkg::NUM_SOURCES-1:0]   operand;
	logic [lts_pkg::NUM_LAMPS-1:0]     lamp_req;
	logic                              i_reset_button;
	logic [lts_pkg::NUM_LAMPS-1:0]     o_lamp;
	logic                              o_target_clear;
	logic                              o_active;
	logic                              o_start_event;
	int                                error_cnt = 0;
	int                                comparisons = 0;
	int                                cycles = 0;
	int                                starts = 0;
	logic [lts_pkg::DATA_W-1:0]        rd;
	logic                              err;

	lts_sequencer
	#(
		.TICK_CYCLES (MS),
		.NUM_SOURCES (lts_pkg::NUM_SOURCES)
	)
	u_lts_sequencer
	(
		.i_clk          (i_clk),
		.i_sys_rst      (i_sys_rst),
		.i_clk_en       (i_clk_en),
		.i_psel         (i_psel),
		.i_penable      (i_penable),
		.i_pwrite       (i_pwrite),
		.i_paddr        (i_paddr),
		.i_pwdata       (i_pwdata),
		.o_prdata       (o_prdata),
		.o_pready       (o_pready),
		.o_pslverr      (o_pslverr),
		.i_operand      (operand),
		.i_lamp_req     (lamp_req),
		.i_reset_button (i_reset_button),
		.o_lamp         (o_lamp),
		.o_target_clear (o_target_clear),
		.o_active       (o_active),
		.o_start_event  (o_start_event)
	);

	lts_partner
	#(
		.TICK (MS)
	)
	u_lts_partner
	(
		.i_clk      (i_clk),
		.o_operand  (operand),
		.o_lamp_req (lamp_req)
	);

	initial
	begin
		i_clk = 1'b0;
	end

	always #50 i_clk = ~i_clk;

	// Hang guard: whole run needs about 10.5k cycles
	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			error_cnt = error_cnt + 1;
			test_done();
		end
	end

	always @(posedge i_clk)
	begin
		if (o_start_event === 1'b1)
			starts <= starts + 1;
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic test_done();
		$display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [lts_pkg::ADDR_W-1:0] a,
		input logic [lts_pkg::DATA_W-1:0] d);
		@(posedge i_clk);
		i_psel    <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite  <= wr;
		i_paddr   <= a;
		i_pwdata  <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		// No cycle limit here; the bench timeout ends a hang
		do
			@(posedge i_clk);
		while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask

	// Waits for the lamp drive to move; returns cycles it stood
	task automatic wait_change(input int lim, output int n);
		logic [lts_pkg::NUM_LAMPS-1:0] was;
		@(negedge i_clk);
		was = o_lamp;
		n = 1;
		while (o_lamp === was && n < lim)
		begin
			@(negedge i_clk);
			n++;
		end
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic test_regs();
		apb(1'b0, lts_pkg::ADDR_CTRL, 32'h0);
		chk_vec(rd, 64'h0);
		apb(1'b0, lts_pkg::ADDR_SELECT, 32'h0);
		chk_vec(rd, 64'h0);
		apb(1'b1, lts_pkg::ADDR_SELECT, 32'h00000003);
		apb(1'b0, lts_pkg::ADDR_SELECT, 32'h0);
		chk_vec(rd, 64'h3);
		apb(1'b0, 12'h020, 32'h0);
		chk_bit(err, 1'b1);
		apb(1'b1, lts_pkg::ADDR_STATUS, 32'hFFFFFFFF);
		chk_bit(err, 1'b1);
		apb(1'b0, lts_pkg::ADDR_STATUS, 32'h0);
		chk_vec(rd, 64'h2);
		@(posedge i_clk);
		i_reset_button <= 1'b1;
		repeat (2) @(negedge i_clk);
		chk_bit(o_target_clear, 1'b1);
	endtask

	task automatic test_ignored();
		u_lts_partner.press(3, 300);
		repeat (300 * MS) @(posedge i_clk);
		chk_vec(starts, 64'h0);
		apb(1'b1, lts_pkg::ADDR_CTRL, 32'h00000001);
		apb(1'b0, lts_pkg::ADDR_CTRL, 32'h0);
		chk_vec(rd, 64'h1);
		u_lts_partner.press(3, 100);
		u_lts_partner.press(5, 300);
		repeat (300 * MS) @(posedge i_clk);
		chk_vec(starts, 64'h0);
	endtask

	task automatic test_run();
		int n;
		fork
			u_lts_partner.press(3, 400);
			begin
				n = 0;
				while (o_start_event !== 1'b1 && n < 300 * MS)
				begin
					@(negedge i_clk);
					n++;
				end
				chk_bit(o_active, 1'b1);
				@(negedge i_clk);
				chk_vec(o_lamp, ALL);
				chk_bit(o_start_event, 1'b0);
				chk_bit(o_target_clear, 1'b0);
				u_lts_partner.set_lamps(PAT);
				repeat (10) @(negedge i_clk);
				chk_vec(o_lamp, ALL);
				apb(1'b0, lts_pkg::ADDR_SHADOW_LO, 32'h0);
				chk_vec(rd, PAT[31:0]);
				apb(1'b0, lts_pkg::ADDR_SHADOW_HI, 32'h0);
				chk_vec(rd, PAT[61:32]);
			end
		join
		wait_change(600 * MS, n);
		chk_vec(o_lamp, 64'h0);
		wait_change(STEP + 10, n);
		chk_vec(o_lamp, 64'h1);
		wait_change(STEP + 10, n);
		chk_vec(o_lamp, 64'h2);
		chk_vec(n, STEP);
		// Walk index 1, stage two, lead over, active
		apb(1'b0, lts_pkg::ADDR_STATUS, 32'h0);
		chk_vec(rd, 64'h49);
		wait_change(STEP + 10, n);
		chk_vec(o_lamp, 64'h4);
		u_lts_partner.press(3, 300);
		repeat (2) @(negedge i_clk);
		chk_bit(o_active, 1'b0);
		chk_vec(o_lamp, PAT);
		chk_bit(o_target_clear, 1'b1);
		chk_vec(starts, 64'h1);
	endtask

	initial
	begin
		i_sys_rst      = 1'b1;
		i_clk_en       = 1'b1;
		i_psel         = 1'b0;
		i_penable      = 1'b0;
		i_pwrite       = 1'b0;
		i_paddr        = '0;
		i_pwdata       = '0;
		i_reset_button = 1'b0;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		test_regs();
		test_ignored();
		test_run();
		test_done();
	end
endmodule
`default_nettype wire
